// >>> src/mrsu_pkg.sv
// constants and types for the multiply-accumulate rounding unit
//------------------------------------------------------------
// Operation
// RL1 - integer mode: 16-bit operands, 40-bit accumulator
// RL2 - fractional operands: point between bits 15, 14
// RL3 - fractional accumulator point between bits 31, 30
// RL4 - round accumulator bits 31..16 half-to-even
// RL5 - round in stage three, after shift, acc0 write
// RL6 - rounding never alters the accumulator
// RL7 - integer mode rounds exactly like fractional
// RL8 - low half above/below 0x8000 rounds up/down
// RL9 - exact 0x8000 rounds up only when odd
// RL10 - saturated positive overflow reads 0x7FFF
// RL11 - saturated negative overflow reads 0x8000
// RL12 - saturate off: never clamp rounded result
// RL13 - rounded result is 16 LSBs, sign separate
// RL14 - operand B low write starts operation
// RL15 - config 0Ah clears accumulator, fractional mode
// RL16 - zero result sets zero flag, status 0x04
// RL17 - accumulator after two cycles, rounded after three
// RL18 - multiply-only mode replaces accumulator
// RL19 - software left and right accumulator shifts
// RL20 - top byte bits 39..32 plus four bytes
// RL21 - fractional product shifted left one bit
//------------------------------------------------------------
`default_nettype none
package mrsu_pkg;
   // register selects on the special-function write port
   typedef enum logic [3:0] {
      MRSU_SEL_CFG  = 4'h0,
      MRSU_SEL_AH   = 4'h1,
      MRSU_SEL_AL   = 4'h2,
      MRSU_SEL_BH   = 4'h3,
      MRSU_SEL_BL   = 4'h4,
      MRSU_SEL_ATOP = 4'h5,
      MRSU_SEL_ACC3 = 4'h6,
      MRSU_SEL_ACC2 = 4'h7,
      MRSU_SEL_ACC1 = 4'h8,
      MRSU_SEL_ACC0 = 4'h9,
      MRSU_SEL_STA  = 4'hA
   } mrsu_sel_e;
   // configuration bit positions
   localparam int MRSU_CFG_MULT_ONLY = 0;
   localparam int MRSU_CFG_FRAC      = 1;
   localparam int MRSU_CFG_SAT       = 2;
   localparam int MRSU_CFG_CLEAR     = 3;
   localparam int MRSU_CFG_SHIFT     = 4;
   localparam int MRSU_CFG_SHIFT_DIR = 5;
   localparam logic [7:0] MRSU_CFG_RESET = 8'h00;
   // status bit positions
   localparam int MRSU_STA_OVF  = 0;
   localparam int MRSU_STA_NEG  = 1;
   localparam int MRSU_STA_ZERO = 2;
   localparam int MRSU_STA_SOVF = 3;
   localparam logic [7:0] MRSU_STA_RESET = 8'h00;
   // rounding threshold and saturation limits
   localparam logic [15:0] MRSU_HALF    = 16'h8000;
   localparam logic [15:0] MRSU_SAT_POS = 16'h7FFF;
   localparam logic [15:0] MRSU_SAT_NEG = 16'h8000;
   // one software write to the unit
   typedef struct packed {
      logic       wr;
      mrsu_sel_e  sel;
      logic [7:0] data;
   } mrsu_sfr_wr_s;
   // state seen by software
   typedef struct packed {
      logic [39:0] acc;
      logic [15:0] rnd;
      logic [7:0]  cfg;
      logic [7:0]  sta;
   } mrsu_view_s;
endpackage
`default_nettype wire

// >>> src/mrsu_top.sv
// multiply-accumulate datapath with rounding and saturation engine
`timescale 1ns/1ps
`default_nettype none
module mrsu_top
   import mrsu_pkg::*;
#(
   parameter int OP_W  = 16,   // operand width
   parameter int ACC_W = 40    // accumulator width
)(
   // clock, reset, enable
   input  wire logic         sys_clk_i,
   input  wire logic         sys_rst_i,
   input  wire logic         ce_i,
   // processor special-function writes
   input  wire mrsu_sfr_wr_s sfr_i,
   // software-visible registers
   output var  mrsu_view_s   view_o,
   // pipeline activity, high while an operation is in flight
   output logic              busy_o
);

   //------------------------------------------------------------
   // state
   //------------------------------------------------------------
   logic [7:0]        cfg_reg, cfg_next;        // configuration
   logic [7:0]        sta_reg, sta_next;        // status flags
   logic [OP_W-1:0]   opa_reg, opa_next;        // operand A
   logic [OP_W-1:0]   opb_reg, opb_next;        // operand B
   logic [ACC_W-1:0]  acc_reg, acc_next;        // accumulator
   logic [15:0]       rnd_reg, rnd_next;        // rounded result
   logic [2*OP_W-1:0] prod_reg, prod_next;      // stage one product
   logic              s1_reg, s1_next;          // product valid
   logic              s1_mo_reg, s1_mo_next;    // multiply-only flag
   logic              s2_reg, s2_next;          // round request

   // combinational helpers
   logic [OP_W-1:0]    opb_new;                 // B with fresh low byte
   logic [2*OP_W-1:0]  prod_raw;                // signed product
   logic [ACC_W-1:0]   prod_ext;                // aligned product
   logic [ACC_W-1:0]   acc_sum;                 // accumulate result
   logic               acc_ovf;                 // 40-bit overflow
   logic [15:0]        lo_half;                 // acc bits 15..0
   logic               rnd_up;                  // round direction
   logic [24:0]        rnd_sum;                 // sign-extended bits 39..16 plus carry
   logic               rnd_ovf;                 // beyond 16-bit signed
   logic               start_op;                // B low written

   //------------------------------------------------------------
   // datapath arithmetic
   //------------------------------------------------------------
   // the product is taken from the value being written so that the
   // operation starts in the same cycle as the low-byte write
   always_comb
   begin
      start_op = sfr_i.wr && (sfr_i.sel == MRSU_SEL_BL);   // see RL14
      opb_new  = {opb_reg[OP_W-1:8], sfr_i.data};          // see RL14
      // signed operands, both modes multiply the same bits
      prod_raw = $signed(opa_reg) * $signed(opb_new);     // see RL1
      // fractional 1.15 x 1.15 gives 2.30; one left shift lands the
      // point between bits 31 and 30 of the accumulator; the shift is
      // done on a widened copy so the product's top bit is never lost
      if (cfg_reg[MRSU_CFG_FRAC])
      begin
         prod_ext = ACC_W'($signed({prod_reg, 1'b0}));      // see RL2, RL21, RL3
      end
      else
      begin
         prod_ext = ACC_W'($signed(prod_reg));              // see RL1
      end
      // accumulate or replace
      if (s1_mo_reg)
      begin
         acc_sum = prod_ext;                                // see RL18
      end
      else
      begin
         acc_sum = acc_reg + prod_ext;                      // see RL3
      end
      // overflow when both addends agree in sign and the sum does not
      acc_ovf = !s1_mo_reg && (acc_reg[ACC_W-1] == prod_reg[2*OP_W-1])
                && (acc_sum[ACC_W-1] != acc_reg[ACC_W-1]);
   end

   //------------------------------------------------------------
   // rounding engine
   //------------------------------------------------------------
   // looks only at the registered accumulator, computes rnd_up, rnd_sum and rnd_ovf
   always_comb
   begin
      lo_half = acc_reg[15:0];
      // half-to-even: above half up, below down, tie to even
      if (lo_half > MRSU_HALF)
      begin
         rnd_up = 1'b1;                                    // see RL8
      end
      else if (lo_half == MRSU_HALF)
      begin
         rnd_up = acc_reg[16];                             // see RL9
      end
      else
      begin
         rnd_up = 1'b0;                                    // see RL8
      end
      // wide sum keeps the overflow visible; same path in both modes
      // one guard bit so a carry out of bit 39 cannot flip the sign
      rnd_sum = {acc_reg[ACC_W-1], acc_reg[ACC_W-1:16]} + {24'h000000, rnd_up}; // see RL4, RL7
      rnd_ovf = (rnd_sum[24:15] != {10{rnd_sum[24]}});
   end

   //------------------------------------------------------------
   // next-state logic
   //------------------------------------------------------------
   always_comb
   begin
      cfg_next   = cfg_reg;
      sta_next   = sta_reg;
      opa_next   = opa_reg;
      opb_next   = opb_reg;
      acc_next   = acc_reg;
      rnd_next   = rnd_reg;
      prod_next  = prod_reg;
      s1_next    = 1'b0;
      s1_mo_next = s1_mo_reg;
      s2_next    = 1'b0;

      // software register writes
      if (sfr_i.wr)
      begin
         unique case (sfr_i.sel)
            MRSU_SEL_CFG:
            begin
               // clear and shift are actions, never stored
               cfg_next = sfr_i.data;
               cfg_next[MRSU_CFG_CLEAR] = 1'b0;
               cfg_next[MRSU_CFG_SHIFT] = 1'b0;
               if (sfr_i.data[MRSU_CFG_CLEAR])
               begin
                  acc_next = '0;                           // see RL15
               end
               else if (sfr_i.data[MRSU_CFG_SHIFT])
               begin
                  // arithmetic right keeps the sign
                  if (sfr_i.data[MRSU_CFG_SHIFT_DIR])
                  begin
                     acc_next = ACC_W'($signed(acc_reg) >>> 1); // see RL19
                  end
                  else
                  begin
                     acc_next = acc_reg << 1;              // see RL19
                  end
                  s2_next = 1'b1;                          // see RL5
               end
            end
            MRSU_SEL_AH:   opa_next[OP_W-1:8] = sfr_i.data;
            MRSU_SEL_AL:   opa_next[7:0]      = sfr_i.data;
            MRSU_SEL_BH:   opb_next[OP_W-1:8] = sfr_i.data;
            MRSU_SEL_BL:
            begin
               // stage one: capture product and mode
               opb_next   = opb_new;
               prod_next  = prod_raw;                      // see RL14
               s1_next    = 1'b1;
               s1_mo_next = cfg_reg[MRSU_CFG_MULT_ONLY];   // see RL18
            end
            MRSU_SEL_ATOP: acc_next[39:32] = sfr_i.data;   // see RL20
            MRSU_SEL_ACC3: acc_next[31:24] = sfr_i.data;   // see RL20
            MRSU_SEL_ACC2: acc_next[23:16] = sfr_i.data;   // see RL20
            MRSU_SEL_ACC1: acc_next[15:8]  = sfr_i.data;   // see RL20
            MRSU_SEL_ACC0:
            begin
               acc_next[7:0] = sfr_i.data;                 // see RL20
               s2_next = 1'b1;                             // see RL5
            end
            MRSU_SEL_STA:  sta_next = sfr_i.data;
            default:
            begin
               // unmapped selects are ignored
            end
         endcase
      end

      // stage two: accumulate; wins over a software byte write
      if (s1_reg)
      begin
         acc_next = acc_sum;                               // see RL17
         s2_next  = 1'b1;
         sta_next[MRSU_STA_ZERO] = (acc_sum == '0);        // see RL16
         sta_next[MRSU_STA_NEG]  = acc_sum[ACC_W-1];       // see RL13
         // sticky: the hardware set beats a same-cycle clear
         if (acc_ovf)
         begin
            sta_next[MRSU_STA_OVF] = 1'b1;
         end
      end

      // stage three: round into the result register; a clamp also sets the SOVF flag
      if (s2_reg)
      begin
         if (cfg_reg[MRSU_CFG_SAT] && rnd_ovf)
         begin
            sta_next[MRSU_STA_SOVF] = 1'b1;
            if (rnd_sum[24])
            begin
               rnd_next = MRSU_SAT_NEG;                    // see RL11
            end
            else
            begin
               rnd_next = MRSU_SAT_POS;                    // see RL10
            end
         end
         else
         begin
            // no clamp: keep only the 16 low bits, wrap allowed
            rnd_next = rnd_sum[15:0];                      // see RL12, RL13, RL6
         end
      end
   end

   //------------------------------------------------------------
   // registers
   //------------------------------------------------------------
   // clock enable low freezes every flop, pipeline included
   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i)
      begin
         cfg_reg   <= MRSU_CFG_RESET;
         sta_reg   <= MRSU_STA_RESET;
         opa_reg   <= '0;
         opb_reg   <= '0;
         acc_reg   <= '0;
         rnd_reg   <= '0;
         prod_reg  <= '0;
         s1_reg    <= 1'b0;
         s1_mo_reg <= 1'b0;
         s2_reg    <= 1'b0;
      end
      else if (ce_i)
      begin
         cfg_reg   <= cfg_next;
         sta_reg   <= sta_next;
         opa_reg   <= opa_next;
         opb_reg   <= opb_next;
         acc_reg   <= acc_next;
         rnd_reg   <= rnd_next;
         prod_reg  <= prod_next;
         s1_reg    <= s1_next;
         s1_mo_reg <= s1_mo_next;
         s2_reg    <= s2_next;
      end
   end

   //------------------------------------------------------------
   // outputs
   //------------------------------------------------------------
   always_comb
   begin
      view_o.acc = acc_reg;
      view_o.rnd = rnd_reg;
      view_o.cfg = cfg_reg;
      view_o.sta = sta_reg;
      busy_o     = s1_reg || s2_reg;
   end

endmodule
`default_nettype wire

// >>> verification/mrsu_top_props.sv
// assertion checker for the multiply-accumulate rounding unit
`timescale 1ns/1ps
`default_nettype none
module mrsu_top_props
   import mrsu_pkg::*;
#(
   parameter int OP_W  = 16,   // operand width
   parameter int ACC_W = 40    // accumulator width
)(
   // clock, reset, enable
   input wire logic         sys_clk_i,
   input wire logic         sys_rst_i,
   input wire logic         ce_i,
   // watched traffic and state
   input wire mrsu_sfr_wr_s sfr_i,
   input wire mrsu_view_s   view_o,
   input wire logic         busy_o
);
   //----------------------------------------
   // operand shadows and expected product
   //----------------------------------------
   logic [15:0] a_reg;    // operand a as written
   logic [7:0]  bh_reg;   // operand b high byte
   logic [39:0] prod_reg; // product of the last start, aligned
   wire logic   tk = ce_i && sfr_i.wr;                // write taken
   wire logic   st = tk && sfr_i.sel == MRSU_SEL_BL;  // start, an op may already be in flight
   wire logic   qt = ce_i && !sfr_i.wr;               // quiet running cycle
   wire logic   r0 = tk && sfr_i.sel == MRSU_SEL_ACC0 && !busy_o;
   // sign-extend before multiplying so the low 40 bits come out right
   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i)
      begin
         a_reg  <= '0;
         bh_reg <= '0;
      end
      else if (tk && sfr_i.sel == MRSU_SEL_AH) a_reg[15:8] <= sfr_i.data;
      else if (tk && sfr_i.sel == MRSU_SEL_AL) a_reg[7:0] <= sfr_i.data;
      else if (tk && sfr_i.sel == MRSU_SEL_BH) bh_reg <= sfr_i.data;
      if (st)
         prod_reg <= ({{24{a_reg[15]}}, a_reg} * {{24{bh_reg[7]}}, bh_reg, sfr_i.data})
                     << view_o.cfg[MRSU_CFG_FRAC];
   end
   // half-to-even on bits 31..16, clamped only on request
   function automatic logic [15:0] rnd_exp(input logic [39:0] a, input logic sat);
      logic [24:0] r;
      r = {a[39], a[39:16]} + 25'((a[15:0] > MRSU_HALF) || (a[15:0] == MRSU_HALF && a[16]));
      if (sat && r[24:15] != {10{r[15]}})
         return r[24] ? MRSU_SAT_NEG : MRSU_SAT_POS;
      return r[15:0];
   endfunction
   //----------------------------------------
   // properties
   //----------------------------------------
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (sys_rst_i);
   busy_start_a: assert property (st |=> busy_o [*2])
      else $error("busy not held after a start");
   acc_hold_a: assert property (st && !busy_o |=> view_o.acc == $past(view_o.acc))
      else $error("accumulator changed one cycle after a start");
   mac_sum_a: assert property (st && !busy_o && !view_o.cfg[MRSU_CFG_MULT_ONLY] ##1 qt
      |=> view_o.acc == $past(view_o.acc) + prod_reg) else $error("accumulate sum wrong");
   mult_only_a: assert property (st && !busy_o && view_o.cfg[MRSU_CFG_MULT_ONLY] ##1 qt
      |=> view_o.acc == prod_reg) else $error("multiply-only product wrong");
   zero_flag_a: assert property (st && !busy_o ##1 qt |=> (view_o.sta[MRSU_STA_ZERO] ==
      (view_o.acc == '0)) && view_o.sta[MRSU_STA_NEG] == view_o.acc[39])
      else $error("zero or negative flag wrong");
   rnd_op_a: assert property (st && !busy_o ##1 qt [*2] |=> view_o.rnd ==
      rnd_exp($past(view_o.acc), view_o.cfg[MRSU_CFG_SAT])) else $error("rounding after op wrong");
   rnd_acc0_a: assert property (r0 ##1 qt |=> view_o.rnd ==
      rnd_exp($past(view_o.acc), view_o.cfg[MRSU_CFG_SAT])) else $error("rounding after write wrong");
   rnd_keep_acc_a: assert property (r0 ##1 qt |=> $stable(view_o.acc))
      else $error("rounding disturbed the accumulator");
   clear_cfg_a: assert property (tk && sfr_i.sel == MRSU_SEL_CFG && sfr_i.data[MRSU_CFG_CLEAR]
      && !busy_o |=> view_o.acc == '0
      && view_o.cfg[MRSU_CFG_FRAC] == $past(sfr_i.data[MRSU_CFG_FRAC]))
      else $error("clear or mode select wrong");
   cover property (st && view_o.cfg[MRSU_CFG_FRAC]);
   cover property (r0 && view_o.cfg[MRSU_CFG_SAT]);
   cover property (tk && sfr_i.sel == MRSU_SEL_CFG && sfr_i.data[MRSU_CFG_SHIFT]);
endmodule
`default_nettype wire

// >>> verification/mrsu_core_model.sv
// processor core model issuing special-function writes
`timescale 1ns/1ps
`default_nettype none
module mrsu_core_model
   import mrsu_pkg::*;
(
   // clock
   input  wire logic         sys_clk_i,
   // write port toward the unit
   output var  mrsu_sfr_wr_s sfr_o
);
   initial sfr_o = '{wr: 1'b0, sel: MRSU_SEL_CFG, data: 8'h00};
   // one write per cycle, launched just after an edge, held to the next
   task automatic put(input mrsu_sel_e sel, input logic [7:0] data);
      @(posedge sys_clk_i);
      #1 sfr_o = '{wr: 1'b1, sel: sel, data: data};
   endtask
   // release; data flips so a stale byte never looks current
   task automatic idle();
      @(posedge sys_clk_i);
      #1 sfr_o = '{wr: 1'b0, sel: sfr_o.sel, data: ~sfr_o.data};
   endtask
   // operands go in ahead of the starting low-byte write
   task automatic start(input logic [15:0] a, input logic [15:0] b);
      put(MRSU_SEL_AH, a[15:8]);
      put(MRSU_SEL_AL, a[7:0]);
      put(MRSU_SEL_BH, b[15:8]);
      put(MRSU_SEL_BL, b[7:0]);
   endtask
endmodule
`default_nettype wire

// >>> verification/mrsu_top_bench.sv
// self-checking bench for the multiply-accumulate rounding unit
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin fail_count++; \
   $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module mrsu_top_bench
   import mrsu_pkg::*;
;
   logic         sys_clk_i;    // 100 MHz clock
   logic         sys_rst_i;    // synchronous reset
   logic         ce_i;         // clock enable
   mrsu_sfr_wr_s sfr;          // write port from the core model
   mrsu_view_s   view;         // visible state
   logic         busy;         // pipeline activity
   int           fail_count;   // mismatches
   int           total_checks; // comparisons
   // rounding table: accumulator, result without and with clamping
   logic [39:0]  rv [6] = '{40'h0000038001, 40'h0000037FFF, 40'h0000038000,
                            40'h0000028000, 40'h007FFF8000, 40'hFF7FFF0000};
   logic [15:0]  re [2][6] = '{'{16'h4, 16'h3, 16'h4, 16'h2, 16'h8000, 16'h7FFF},
                               '{16'h4, 16'h3, 16'h4, 16'h2, 16'h7FFF, 16'h8000}};
   mrsu_core_model core (.sys_clk_i(sys_clk_i), .sfr_o(sfr));
   mrsu_top dut (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i),
                 .sfr_i(sfr), .view_o(view), .busy_o(busy));
   initial
   begin
      sys_clk_i = 1'b0;
      forever #5 sys_clk_i = ~sys_clk_i;
   end
   // verdict and end of run
   task automatic end_sim();
      if (fail_count == 0 && total_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // release the port, then a bounded wait for the pipeline to drain
   task automatic settle();
      int n;
      n = 0;
      core.idle();
      while (busy === 1'b1 && n < 8)
      begin
         @(posedge sys_clk_i);
         #1 n++;
      end
      if (n == 8)
      begin
         `CHK("busy drain", 1'b0, busy)
         end_sim();
      end
   endtask
   // all five accumulator bytes; the last byte triggers rounding
   task automatic load_acc(input logic [39:0] v);
      core.put(MRSU_SEL_ATOP, v[39:32]);
      core.put(MRSU_SEL_ACC3, v[31:24]);
      core.put(MRSU_SEL_ACC2, v[23:16]);
      core.put(MRSU_SEL_ACC1, v[15:8]);
      core.put(MRSU_SEL_ACC0, v[7:0]);
      settle();
   endtask
   initial
   begin
      fail_count = 0;
      total_checks = 0;
      sys_rst_i = 1'b1;
      ce_i = 1'b1;
      repeat (5) @(posedge sys_clk_i);
      #1 sys_rst_i = 1'b0;
      `CHK("reset view", 72'h0, view)
      // two fractional products back to back cancel to zero
      core.put(MRSU_SEL_CFG, 8'h0A);
      core.start(16'h4000, 16'h2000);
      core.put(MRSU_SEL_BH, 8'hE0);
      core.put(MRSU_SEL_BL, 8'h00);
      settle();
      `CHK("acc zero", 40'h0, view.acc)
      `CHK("status", 8'h04, view.sta)
      `CHK("rnd zero", 16'h0, view.rnd)
      core.start(16'h4000, 16'h2000);
      settle();
      `CHK("frac acc", 40'h0010000000, view.acc)
      `CHK("frac rnd", 16'h1000, view.rnd)
      // integer multiply-only replaces the old sum
      core.put(MRSU_SEL_CFG, 8'h01);
      core.start(16'h0003, 16'hFFFE);
      settle();
      `CHK("mult only", 40'hFFFFFFFFFA, view.acc)
      `CHK("negative", 1'b1, view.sta[MRSU_STA_NEG])
      `CHK("int rnd", 16'h0, view.rnd)
      // integer accumulate, then shifts
      core.put(MRSU_SEL_CFG, 8'h08);
      core.start(16'h0003, 16'h0004);
      core.start(16'hFFFF, 16'h0002);
      settle();
      `CHK("int sum", 40'hA, view.acc)
      core.put(MRSU_SEL_CFG, 8'h10);
      settle();
      `CHK("shift left", 40'h14, view.acc)
      core.put(MRSU_SEL_CFG, 8'h30);
      settle();
      `CHK("shift right", 40'hA, view.acc)
      // unmapped select and frozen enable leave state alone
      core.put(mrsu_sel_e'(4'hF), 8'h55);
      core.idle();
      ce_i = 1'b0;
      core.put(MRSU_SEL_BL, 8'h01);
      core.idle();
      ce_i = 1'b1;
      settle();
      `CHK("ignored", 40'hA, view.acc)
      // rounding table, clamping off then on
      for (int s = 0; s < 2; s++)
      begin
         core.put(MRSU_SEL_CFG, s ? 8'h04 : 8'h00);
         for (int i = 0; i < 6; i++)
         begin
            load_acc(rv[i]);
            `CHK("rounded", re[s][i], view.rnd)
            `CHK("acc kept", rv[i], view.acc)
         end
      end
      // accumulator overflow with clamping still on
      load_acc(40'h7FFFFFFFFF);
      core.start(16'h7FFF, 16'h7FFF);
      settle();
      `CHK("ovf acc", 40'h803FFF0000, view.acc)
      `CHK("ovf rnd", 16'h8000, view.rnd)
      `CHK("ovf status", 8'h0B, view.sta)
      end_sim();
   end
endmodule
bind mrsu_top mrsu_top_props #(.OP_W(OP_W), .ACC_W(ACC_W)) u_props (.sys_clk_i(sys_clk_i),
   .sys_rst_i(sys_rst_i), .ce_i(ce_i), .sfr_i(sfr_i), .view_o(view_o), .busy_o(busy_o));
`default_nettype wire
